// ### pkg/stc_pkg.sv
// constants and types of the safety self-test control block
package stc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_ANA_CTRL = 8'h00;
  localparam logic [7:0] OFF_LOG_CTRL = 8'h04;
  localparam logic [7:0] OFF_ANA_STAT = 8'h08;
  localparam logic [7:0] OFF_LOG_STAT = 8'h0c;
  localparam logic [7:0] OFF_CTL = 8'h10;
  localparam logic [7:0] OFF_DEV = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  // ==========================================================
  // field layouts and reset values
  localparam int ANA_N = 4;
  localparam int LOG_N = 6;
  localparam int LST_W = 7;
  localparam int LOG_RUN = 0;
  localparam int CTL_W = 3;
  localparam int CTL_LOCK = 0;
  localparam int CTL_MASK = 1;
  localparam int CTL_REQ = 2;
  localparam logic [CTL_W-1:0] CTL_RST = 3'h1;
  localparam int CNT_W = 4;
  localparam int DEV_TO = 4;
  localparam int DEV_ST = 5;
  localparam int IRQ_W = 7;
  localparam int IRQ_RUN = 4;
  localparam int IRQ_TO = 5;
  localparam int IRQ_CHK = 6;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 125;
  localparam int DIAG_TO_US = 100;
  localparam int DIAG_TO_CYC = DIAG_TO_US * CLK_MHZ;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_DIAG = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_SAFE = 2'b10
  } stc_state_t;
  typedef struct packed {
    logic [ANA_N-1:0] done;
    logic [ANA_N-1:0] fail;
  } stc_ares_t;
  typedef struct packed {
    logic [LOG_N-1:0] done;
    logic [LST_W-1:0] result;
  } stc_lres_t;
endpackage

// ### design/stc_selftest_ctrl.sv
// safety self-test control: registers, test launch, diag state logic
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// RULE_01 - control registers accept writes only while the write lock is clear
// RULE_02 - both control registers clear on power-on reset and reset event
// RULE_03 - bits 0..3 launch analog groups 1..4; bits 7..4 read-only
// RULE_04 - group finish sets its done flag, and fail flag on failure
// RULE_05 - analog go bit self-clears unless scheduler runs in active state
// RULE_06 - bit 5 runs the logic-test self-check, results D0 and D2
// RULE_07 - bit 4 runs config crc check, result D6, self-clears
// RULE_08 - bit 3 runs nvm crc check, result D5, self-clears
// RULE_09 - bit 2 checks reset-pin monitor, result D4, self-clears
// RULE_10 - bit 1 checks enable-pin monitor, result D3, self-clears
// RULE_11 - bit 0 runs logic test in any state, results D0 D1
// RULE_12 - logic test started in diag clears leave mask, timer keeps running
// RULE_13 - host sets leave mask again after test to stay in diag
// RULE_14 - logic test in active or safe freezes enable pin until done
// RULE_15 - diag timeout moves to safe, sets flag, bumps error counter
// RULE_16 - diag leaves for active when request is 1 and mask is 0
// RULE_17 - writes while locked are ignored and launch nothing
// RULE_18 - reserved control bits read zero and ignore writes
module stc_selftest_ctrl #(
  parameter int DIAG_TO_CYC = stc_pkg::DIAG_TO_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device events
  input wire logic dev_reset_event,
  input wire logic fault_event,
  input wire logic sched_en,
  // analog test engine
  output logic [stc_pkg::ANA_N-1:0] ana_go,
  input wire stc_pkg::stc_ares_t ana_res,
  // logic test and check engine
  output logic [stc_pkg::LOG_N-1:0] log_go,
  input wire stc_pkg::stc_lres_t log_res,
  // enable/interrupt pin
  input wire logic en_pin_req,
  output logic enable_interrupt_pin,
  // state and interrupt
  output stc_pkg::stc_state_t device_state,
  output logic irq
);

  // ==========================================================
  // apb access
  localparam logic [31:0] TO_LAST = 32'(DIAG_TO_CYC - 1);
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdat;
  logic hit;
  logic setup;
  logic wr;
  logic rd;
  logic [stc_pkg::ANA_N-1:0] ana_q;
  logic [stc_pkg::LOG_N-1:0] lbc_q;
  logic [2*stc_pkg::ANA_N-1:0] ast_q;
  logic [stc_pkg::LST_W-1:0] lst_q;
  logic [stc_pkg::CTL_W-1:0] ctl_q;
  logic [stc_pkg::CTL_W-1:0] ctl_d;
  logic [stc_pkg::CNT_W-1:0] cnt_q;
  logic [stc_pkg::IRQ_W-1:0] ist_q;
  logic [stc_pkg::IRQ_W-1:0] imk_q;
  logic [stc_pkg::IRQ_W-1:0] ev;
  logic [31:0] tmr_q;
  logic to_q;
  logic frz_q;
  logic pin_q;
  logic lock;
  logic keep;
  logic wr_ana;
  logic wr_lbc;
  logic start_run;
  logic to_hit;
  stc_pkg::stc_state_t st_q;
  stc_pkg::stc_state_t st_d;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_q & pwrite;
  assign rd = psel & penable & pready_q & ~pwrite;
  assign lock = ctl_q[stc_pkg::CTL_LOCK];
  assign wr_ana = wr & ~lock & (paddr == stc_pkg::OFF_ANA_CTRL); // see RULE_01
  assign wr_lbc = wr & ~lock & (paddr == stc_pkg::OFF_LOG_CTRL); // see RULE_17
  assign keep = sched_en & (st_q == stc_pkg::ST_ACTIVE);
  assign start_run = wr_lbc & pwdata[stc_pkg::LOG_RUN]
    & ~lbc_q[stc_pkg::LOG_RUN];
  assign to_hit = (st_q == stc_pkg::ST_DIAG) & (tmr_q == TO_LAST);
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // reserved bits padded with zero
  always_comb begin
    hit = 1'b1;
    rdat = '0;
    unique case (paddr)
      stc_pkg::OFF_ANA_CTRL: rdat[stc_pkg::ANA_N-1:0] = ana_q; // see RULE_18
      stc_pkg::OFF_LOG_CTRL: rdat[stc_pkg::LOG_N-1:0] = lbc_q;
      stc_pkg::OFF_ANA_STAT: rdat[2*stc_pkg::ANA_N-1:0] = ast_q;
      stc_pkg::OFF_LOG_STAT: rdat[stc_pkg::LST_W-1:0] = lst_q;
      stc_pkg::OFF_CTL: rdat[stc_pkg::CTL_W-1:0] = ctl_q;
      stc_pkg::OFF_DEV: rdat[stc_pkg::DEV_ST+1:0] = {st_q, to_q, cnt_q};
      stc_pkg::OFF_IRQ_STAT: rdat[stc_pkg::IRQ_W-1:0] = ist_q;
      stc_pkg::OFF_IRQ_MASK: rdat[stc_pkg::IRQ_W-1:0] = imk_q;
      default: hit = 1'b0;
    endcase
  end

  // one-cycle access phase, data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= ~hit;
        prdata_q <= rdat;
      end
    end
  end

  // ==========================================================
  // analog test control and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_q <= '0;
    end else if (dev_reset_event) begin
      ana_q <= '0; // see RULE_02
    end else if (wr_ana) begin
      ana_q <= pwdata[stc_pkg::ANA_N-1:0]; // see RULE_03
    end else begin
      ana_q <= ana_q & ~(ana_res.done & {stc_pkg::ANA_N{~keep}}); // see RULE_05
    end
  end

  // sticky done/fail, cleared by read, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ast_q <= '0;
    end else begin
      ast_q <= (rd && paddr == stc_pkg::OFF_ANA_STAT ? '0 : ast_q)
        | {ana_res.done & ana_res.fail, ana_res.done}; // see RULE_04
    end
  end

  assign ana_go = ana_q;

  // ==========================================================
  // logic test and check control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lbc_q <= '0;
    end else if (dev_reset_event) begin
      lbc_q <= '0; // see RULE_02
    end else if (wr_lbc) begin
      lbc_q <= pwdata[stc_pkg::LOG_N-1:0]; // see RULE_06
    end else begin
      lbc_q <= lbc_q & ~log_res.done; // see RULE_08 RULE_09 RULE_10 RULE_11
    end
  end

  // results of the engine captured on any completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lst_q <= '0;
    end else if (|log_res.done) begin
      lst_q <= log_res.result; // see RULE_07
    end
  end

  assign log_go = lbc_q;

  // ==========================================================
  // enable/interrupt pin hold during logic test started in active or safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frz_q <= 1'b0;
    end else if (start_run && st_q != stc_pkg::ST_DIAG) begin
      frz_q <= 1'b1; // see RULE_14
    end else if (!lbc_q[stc_pkg::LOG_RUN]) begin
      frz_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else if (!frz_q) begin
      pin_q <= en_pin_req;
    end
  end

  assign enable_interrupt_pin = pin_q;

  // ==========================================================
  // lock, leave mask and leave request
  always_comb begin
    ctl_d = ctl_q;
    if (wr && paddr == stc_pkg::OFF_CTL) begin
      ctl_d = pwdata[stc_pkg::CTL_W-1:0];
      ctl_d[stc_pkg::CTL_REQ] = pwdata[stc_pkg::CTL_REQ]
        & (st_q == stc_pkg::ST_DIAG);
    end
    if (start_run && st_q == stc_pkg::ST_DIAG) begin
      ctl_d[stc_pkg::CTL_MASK] = 1'b0; // see RULE_12
    end
    if (st_q == stc_pkg::ST_DIAG && st_d != stc_pkg::ST_DIAG) begin
      ctl_d[stc_pkg::CTL_REQ] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= stc_pkg::CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ==========================================================
  // device state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      stc_pkg::ST_DIAG: begin
        if (to_hit) begin
          st_d = stc_pkg::ST_SAFE; // see RULE_15
        end else if (ctl_q[stc_pkg::CTL_REQ] && !ctl_q[stc_pkg::CTL_MASK]) begin
          st_d = stc_pkg::ST_ACTIVE; // see RULE_16
        end
      end
      stc_pkg::ST_ACTIVE: begin
        if (fault_event) begin
          st_d = stc_pkg::ST_SAFE;
        end
      end
      stc_pkg::ST_SAFE: st_d = stc_pkg::ST_SAFE;
      default: st_d = stc_pkg::ST_SAFE;
    endcase
    if (dev_reset_event) begin
      st_d = stc_pkg::ST_DIAG;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= stc_pkg::ST_DIAG;
    end else begin
      st_q <= st_d;
    end
  end

  // timer ignores logic test activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= '0;
    end else if (st_q != stc_pkg::ST_DIAG) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 32'h1; // see RULE_12
    end
  end

  // timeout flag cleared by read, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_q <= 1'b0;
    end else begin
      to_q <= (to_q & ~(rd && paddr == stc_pkg::OFF_DEV)) | to_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (st_q != stc_pkg::ST_SAFE && st_d == stc_pkg::ST_SAFE) begin
      cnt_q <= cnt_q + 4'h1; // see RULE_15
    end
  end

  assign device_state = st_q;

  // ==========================================================
  // interrupt status and mask
  assign ev = {|log_res.done[stc_pkg::LOG_N-1:1], to_hit,
    log_res.done[stc_pkg::LOG_RUN], ana_res.done};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      imk_q <= '0;
    end else begin
      if (wr && paddr == stc_pkg::OFF_IRQ_STAT) begin
        ist_q <= (ist_q & ~pwdata[stc_pkg::IRQ_W-1:0]) | ev;
      end else begin
        ist_q <= ist_q | ev;
      end
      if (wr && paddr == stc_pkg::OFF_IRQ_MASK) begin
        imk_q <= pwdata[stc_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq = |(ist_q & imk_q);

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_locked_write;
    wr && lock && !dev_reset_event && ana_res.done == '0
      && log_res.done == '0 |=> $stable(ana_q) && $stable(lbc_q);
  endproperty
  a_locked_write: assert property (p_locked_write) // see RULE_17
    else $error("locked write changed a control register");

  property p_reset_event;
    dev_reset_event |=> ana_q == '0 && lbc_q == '0
      && st_q == stc_pkg::ST_DIAG;
  endproperty
  a_reset_event: assert property (p_reset_event) // see RULE_02
    else $error("reset event did not clear control");

  property p_ana_launch;
    wr_ana && !dev_reset_event
      |=> ana_go == $past(pwdata[stc_pkg::ANA_N-1:0]);
  endproperty
  a_ana_launch: assert property (p_ana_launch) // see RULE_03
    else $error("analog go bits do not follow write");

  property p_ana_done;
    ana_res.done != '0 |=> (ast_q[stc_pkg::ANA_N-1:0]
      & $past(ana_res.done)) == $past(ana_res.done);
  endproperty
  a_ana_done: assert property (p_ana_done) // see RULE_04
    else $error("analog done flag not set");

  property p_ana_clear;
    ana_res.done != '0 && !keep && !wr_ana && !dev_reset_event
      |=> (ana_q & $past(ana_res.done)) == '0;
  endproperty
  a_ana_clear: assert property (p_ana_clear) // see RULE_05
    else $error("analog go bit did not self-clear");

  property p_log_clear;
    log_res.done != '0 && !wr_lbc
      |=> (lbc_q & $past(log_res.done)) == '0
      && lst_q == $past(log_res.result);
  endproperty
  a_log_clear: assert property (p_log_clear) // see RULE_11
    else $error("logic go bit did not self-clear");

  property p_mask_clear;
    start_run && st_q == stc_pkg::ST_DIAG |=> !ctl_q[stc_pkg::CTL_MASK];
  endproperty
  a_mask_clear: assert property (p_mask_clear) // see RULE_12
    else $error("leave mask not cleared at test start");

  property p_pin_hold;
    start_run && st_q != stc_pkg::ST_DIAG && !dev_reset_event
      ##1 lbc_q[stc_pkg::LOG_RUN] [*2] |-> $stable(enable_interrupt_pin);
  endproperty
  a_pin_hold: assert property (p_pin_hold) // see RULE_14
    else $error("enable pin moved during logic test");

  property p_timeout;
    to_hit && !dev_reset_event |=> st_q == stc_pkg::ST_SAFE && to_q
      && cnt_q == $past(cnt_q) + 4'h1;
  endproperty
  a_timeout: assert property (p_timeout) // see RULE_15
    else $error("diag timeout handling wrong");

  property p_leave;
    st_q == stc_pkg::ST_DIAG && ctl_q[stc_pkg::CTL_REQ]
      && !ctl_q[stc_pkg::CTL_MASK] && !to_hit && !dev_reset_event
      |=> st_q == stc_pkg::ST_ACTIVE && !ctl_q[stc_pkg::CTL_REQ];
  endproperty
  a_leave: assert property (p_leave) // see RULE_16
    else $error("diag did not leave for active");

  property p_reserved;
    pready && psel && !pwrite && paddr == stc_pkg::OFF_LOG_CTRL
      |-> prdata[31:stc_pkg::LOG_N] == '0;
  endproperty
  a_reserved: assert property (p_reserved) // see RULE_18
    else $error("reserved control bits read nonzero");

endmodule

// ### verif/safety_selftest_control_tb.sv
// self-checking testbench of the safety self-test control block
`timescale 1ns/1ps
module safety_selftest_control_tb;
  localparam int TO_CYC = 600;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dev_reset_event = 1'b0;
  logic fault_event = 1'b0;
  logic sched_en = 1'b0;
  logic [stc_pkg::ANA_N-1:0] ana_go;
  stc_pkg::stc_ares_t ana_res = '0;
  logic [stc_pkg::LOG_N-1:0] log_go;
  stc_pkg::stc_lres_t log_res = '0;
  logic en_pin_req = 1'b0;
  logic enable_interrupt_pin;
  stc_pkg::stc_state_t device_state;
  logic irq;
  int failures = 0;
  int checks = 0;
  logic [31:0] rd;
  logic err;
  logic [3:0] cnt0;
  // check rows: go bit driven, result word expected
  int row_bit [5] = '{5, 4, 3, 2, 1};
  logic [6:0] row_res [5] = '{7'h05, 7'h40, 7'h20, 7'h10, 7'h08};

  always #4 pclk = ~pclk;

  stc_selftest_ctrl #(.DIAG_TO_CYC(TO_CYC)) dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .dev_reset_event(dev_reset_event),
    .fault_event(fault_event),
    .sched_en(sched_en),
    .ana_go(ana_go),
    .ana_res(ana_res),
    .log_go(log_go),
    .log_res(log_res),
    .en_pin_req(en_pin_req),
    .enable_interrupt_pin(enable_interrupt_pin),
    .device_state(device_state),
    .irq(irq)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; answer taken at the edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ana_done(input logic [3:0] d, input logic [3:0] f);
    @(posedge pclk);
    ana_res <= {d, f};
    @(posedge pclk);
    ana_res <= '0;
    repeat (2) @(negedge pclk);
  endtask

  task automatic log_done(input logic [5:0] d, input logic [6:0] r);
    @(posedge pclk);
    log_res <= {d, r};
    @(posedge pclk);
    log_res <= '0;
    repeat (2) @(negedge pclk);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, stc_pkg::OFF_ANA_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, stc_pkg::OFF_LOG_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, stc_pkg::OFF_ANA_CTRL, 32'h0f);
    apb(1'b0, stc_pkg::OFF_ANA_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk(ana_go, 32'h0);
    $display("test reset and lock ended");
    // unlock with leave mask set so diag is held
    apb(1'b1, stc_pkg::OFF_CTL, 32'h2);
    apb(1'b1, stc_pkg::OFF_ANA_CTRL, 32'hff);
    @(negedge pclk);
    chk(ana_go, 32'hf);
    apb(1'b0, stc_pkg::OFF_ANA_CTRL, 32'h0);
    chk(rd, 32'h0f);
    ana_done(4'h1, 4'h1);
    chk(ana_go, 32'he);
    ana_done(4'he, 4'h0);
    chk(ana_go, 32'h0);
    apb(1'b0, stc_pkg::OFF_ANA_STAT, 32'h0);
    chk(rd, 32'h1f);
    chk(irq, 32'h0);
    apb(1'b1, stc_pkg::OFF_IRQ_MASK, 32'h1);
    @(negedge pclk);
    chk(irq, 32'h1);
    apb(1'b1, stc_pkg::OFF_IRQ_STAT, 32'h0f);
    @(negedge pclk);
    chk(irq, 32'h0);
    $display("test analog groups ended");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, stc_pkg::OFF_LOG_CTRL, 32'(1) << row_bit[i]);
      @(negedge pclk);
      chk(log_go, 32'(1) << row_bit[i]);
      log_done(6'(1 << row_bit[i]), row_res[i]);
      chk(log_go, 32'h0);
      apb(1'b0, stc_pkg::OFF_LOG_STAT, 32'h0);
      chk(rd, {25'h0, row_res[i]});
    end
    $display("test check rows ended");
    apb(1'b1, stc_pkg::OFF_LOG_CTRL, 32'h1);
    apb(1'b0, stc_pkg::OFF_CTL, 32'h0);
    chk(rd, 32'h0);
    chk(device_state, stc_pkg::ST_DIAG);
    log_done(6'h01, 7'h03);
    chk(log_go, 32'h0);
    apb(1'b0, stc_pkg::OFF_LOG_STAT, 32'h0);
    chk(rd, 32'h03);
    apb(1'b1, stc_pkg::OFF_CTL, 32'h2);
    apb(1'b1, stc_pkg::OFF_CTL, 32'h6);
    repeat (3) @(negedge pclk);
    chk(device_state, stc_pkg::ST_DIAG);
    apb(1'b1, stc_pkg::OFF_CTL, 32'h4);
    repeat (3) @(negedge pclk);
    chk(device_state, stc_pkg::ST_ACTIVE);
    $display("test diag run and leave ended");
    @(posedge pclk);
    sched_en <= 1'b1;
    en_pin_req <= 1'b1;
    apb(1'b1, stc_pkg::OFF_ANA_CTRL, 32'h2);
    ana_done(4'h2, 4'h0);
    chk(ana_go, 32'h2);
    apb(1'b1, stc_pkg::OFF_LOG_CTRL, 32'h1);
    en_pin_req <= 1'b0;
    repeat (4) @(negedge pclk);
    chk(enable_interrupt_pin, 32'h1);
    log_done(6'h01, 7'h00);
    repeat (2) @(negedge pclk);
    chk(enable_interrupt_pin, 32'h0);
    $display("test active run ended");
    @(posedge pclk);
    fault_event <= 1'b1;
    @(posedge pclk);
    fault_event <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(device_state, stc_pkg::ST_SAFE);
    @(posedge pclk);
    dev_reset_event <= 1'b1;
    @(posedge pclk);
    dev_reset_event <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(ana_go, 32'h0);
    chk(device_state, stc_pkg::ST_DIAG);
    apb(1'b0, stc_pkg::OFF_DEV, 32'h0);
    cnt0 = rd[3:0];
    repeat (TO_CYC + 10) @(negedge pclk);
    chk(device_state, stc_pkg::ST_SAFE);
    apb(1'b0, stc_pkg::OFF_DEV, 32'h0);
    chk(rd, {25'h0, 2'b10, 1'b1, 4'(cnt0 + 4'h1)});
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("test timeout and unmapped ended");
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    stop_test();
  end
endmodule
